// ### core/gps_map.svh
// register offsets, field positions and reset values of the pin sense and remap block
`ifndef GPS_MAP_SVH
`define GPS_MAP_SVH
`define GPS_OFF_IRQ_LEVEL 12'h024
`define GPS_OFF_IRQ0_SEL 12'h028
`define GPS_OFF_IRQ1_SEL 12'h02c
`define GPS_OFF_FLAGS 12'h030
`define GPS_OFF_REMAP 12'h038
`define GPS_OFF_INPUT 12'h020
`define GPS_OFF_PINCFG0 12'h040
`define GPS_IDX_IRQ_LEVEL 12'h009
`define GPS_IDX_IRQ0_SEL 12'h00a
`define GPS_IDX_IRQ1_SEL 12'h00b
`define GPS_IDX_FLAGS 12'h00c
`define GPS_IDX_REMAP 12'h00e
`define GPS_IDX_INPUT 12'h008
`define GPS_IDX_PINCFG0 12'h010
`define GPS_RST_BYTE 8'h00
`define GPS_FLAGS_MASK 8'h03
`define GPS_LEVEL_MASK 8'h0f
`define GPS_REMAP_MASK 8'h3f
`define GPS_BIT_SLEW 7
`define GPS_BIT_INV 6
`define GPS_REMAP_SPI 5
`define GPS_REMAP_SER0 4
`define GPS_SYNC_STAGES 2
`endif

// ### core/gps_pin_sense.sv
// one pin: synchroniser, inversion and sense detection
module gps_pin_sense
   import gps_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pclken,
   input wire logic pin_in,
   input wire gps_pin_config_t cfg,
   input wire logic buffer_off_allowed,
   output logic pin_level,
   output logic sense_hit
);
   `include "gps_map.svh"
   logic [`GPS_SYNC_STAGES-1:0] sync;
   logic prev;
   logic buf_off;
   logic lvl;
   assign buf_off = buffer_off_allowed && (cfg.sense_select == GPS_INPUT_BUFFER_OFF);
   // synchronise before any detection
   always_ff @(posedge pclk or negedge presetn) begin // see R22
      if (!presetn) begin
         sync <= '0;
      end else if (pclken) begin
         sync <= {sync[`GPS_SYNC_STAGES-2:0], pin_in};
      end
   end
   assign lvl = sync[`GPS_SYNC_STAGES-1] ^ cfg.pin_invert; // see R12
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev <= 1'b0;
         pin_level <= 1'b0;
      end else if (pclken) begin
         prev <= lvl;
         // buffer off: not sampled, reads zero
         pin_level <= buf_off ? 1'b0 : lvl; // see R16, R21
      end
   end
   always_comb begin // see R14, R15
      unique case (cfg.sense_select)
         GPS_SENSE_ANY_EDGE: sense_hit = lvl ^ prev;
         GPS_SENSE_RISE: sense_hit = lvl & ~prev;
         GPS_SENSE_FALL: sense_hit = ~lvl & prev;
         GPS_SENSE_LOW: sense_hit = ~lvl; // see R17
         GPS_INPUT_BUFFER_OFF: sense_hit = 1'b0;
         default: sense_hit = 1'b0;
      endcase
   end
endmodule // gps_pin_sense

// ### core/gps_pkg.sv
// types shared by the pin sense and remap block
package gps_pkg;
   typedef enum logic [2:0] {
      GPS_SENSE_ANY_EDGE = 3'b000,
      GPS_SENSE_RISE = 3'b001,
      GPS_SENSE_FALL = 3'b010,
      GPS_SENSE_LOW = 3'b011,
      GPS_SENSE_RSV4 = 3'b100,
      GPS_SENSE_RSV5 = 3'b101,
      GPS_SENSE_RSV6 = 3'b110,
      GPS_INPUT_BUFFER_OFF = 3'b111
   } gps_sense_t;
   typedef enum logic [2:0] {
      GPS_TOTEM = 3'b000,
      GPS_HOLD_LAST_LEVEL = 3'b001,
      GPS_PULL_DOWN = 3'b010,
      GPS_PULL_UP = 3'b011,
      GPS_WIRED_OR = 3'b100,
      GPS_WIRED_AND = 3'b101,
      GPS_OPEN_SOURCE_WITH_PULLDOWN = 3'b110,
      GPS_OPEN_DRAIN_WITH_PULLUP = 3'b111
   } gps_drive_t;
   typedef struct packed {
      logic slew_limit_on;
      logic pin_invert;
      gps_drive_t drive_pull_select;
      gps_sense_t sense_select;
   } gps_pin_config_t;
   typedef struct packed {
      logic spi_swap;
      logic serial0_relocate;
      logic relocate_cmp_d;
      logic relocate_cmp_c;
      logic relocate_cmp_b;
      logic relocate_cmp_a;
   } gps_remap_t;
   typedef struct packed {
      logic [3:0] cmp_out;
      logic [3:0] cmp_oe;
      logic [3:0] t1_pwm;
      logic [3:0] t1_pwm_oe;
      logic [3:0] serial_out;
      logic [3:0] serial_oe;
   } gps_periph_t;
endpackage

// ### core/gps_port.sv
// 8-bit port: pin config, sense interrupts, peripheral pin relocation, APB slave
// Summary of operation
// R1 - irq0 pin select bit one makes that pin feed interrupt source 0
// R2 - irq1 pin select at 0x0b chooses pins feeding interrupt source 1
// R3 - flag n sets when a selected pin meets its sense mode
// R4 - writing one clears a flag, zero leaves it
// R5 - software writes zero to flag bits 7:2; they read zero
// R6 - relocation register exists only on ports with PORT_INDEX two to five
// R7 - remap bit 5 swaps SCK and MOSI pin positions
// R8 - remap bit 4 moves serial unit 0 from low to high nibble
// R9 - remap bits 3:0 move compare D,C,B,A from pins 3..0 to 7..4
// R10 - relocated A or B with both timers PWM gives OR of both
// R11 - config bit 7 turns on slew limiting
// R12 - config bit 6 inverts output and input data
// R13 - bits 5:3 pick totem, keeper, pulls, wired-OR/AND modes
// R14 - bits 2:0 pick edges, low level, or input buffer off
// R15 - sense mode governs both interrupt flags and events
// R16 - buffer off: pin not sampled, input register ignores it
// R17 - low level mode: low pin no events, high pin continuous events
// R18 - input buffer disable supported only on first six ports
// R19 - software should disable input buffer on analog pins
// R20 - each source raises request only when its 2-bit level is nonzero
// R21 - input value bits show pin levels while buffer enabled
// R22 - pins synchronised to clock before edge or level detection
module gps_port
   import gps_pkg::*;
#(
   parameter int PORT_INDEX = 2,
   parameter int NUM_PINS = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pclken,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // pad and peripheral side
   input wire logic [NUM_PINS-1:0] pin_in,
   input wire logic [NUM_PINS-1:0] port_out,
   input wire logic [NUM_PINS-1:0] port_dir,
   input wire gps_periph_t periph,
   output logic [NUM_PINS-1:0] pin_out,
   output logic [NUM_PINS-1:0] pin_oe,
   output logic [NUM_PINS-1:0] pin_pullup,
   output logic [NUM_PINS-1:0] pin_pulldown,
   output logic [NUM_PINS-1:0] pin_keeper,
   output logic [NUM_PINS-1:0] pin_slew_limit,
   output logic [NUM_PINS-1:0] pin_buffer_off,
   output logic [NUM_PINS-1:0] pin_events,
   output logic [NUM_PINS-1:0] pin_level,
   // interrupt controller side
   output logic [1:0] irq_req,
   output logic [3:0] irq_priority_level
);
   `include "gps_map.svh"
   localparam bit HAS_REMAP = (PORT_INDEX >= 2) && (PORT_INDEX <= 5);
   localparam bit HAS_BUF_OFF = (PORT_INDEX <= 5);

   gps_pin_config_t pin_config [NUM_PINS];
   logic [7:0] irq0_pin_select;
   logic [7:0] irq1_pin_select;
   logic [1:0] port_irq_flag;
   logic [3:0] level_reg;
   gps_remap_t remap;
   logic [NUM_PINS-1:0] hit;
   logic [NUM_PINS-1:0] drv_val;
   logic [NUM_PINS-1:0] drv_en;
   logic [1:0] set_ev;
   logic [1:0] clr_ev;
   logic wr_acc;
   logic rd_acc;
   logic [31:0] next_prdata;
   logic [11:0] pin_cfg_top;
   logic wr_any;
   logic wr_level;
   logic wr_sel0;
   logic wr_sel1;
   logic wr_flags;
   logic wr_remap;
   logic [3:0] cmp_moved;
   logic serial_high;
   logic sck_mosi_swap;

   function automatic logic is_pincfg(input logic [11:0] a);
      return (a >= 12'(`GPS_OFF_PINCFG0)) && (a < pin_cfg_top) && (a[1:0] == 2'b00);
   endfunction

   function automatic int pincfg_idx(input logic [11:0] a);
      return int'((a - 12'(`GPS_OFF_PINCFG0)) >> 2);
   endfunction

   assign pin_cfg_top = 12'(`GPS_OFF_PINCFG0) + 12'(NUM_PINS * 4);
   assign wr_acc = psel && penable && pwrite && pclken;
   assign rd_acc = psel && !penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign wr_any = wr_acc && pstrb[0];
   assign wr_level = wr_any && (paddr == `GPS_OFF_IRQ_LEVEL);
   assign wr_sel0 = wr_any && (paddr == `GPS_OFF_IRQ0_SEL);
   assign wr_sel1 = wr_any && (paddr == `GPS_OFF_IRQ1_SEL);
   assign wr_flags = wr_any && (paddr == `GPS_OFF_FLAGS);
   assign wr_remap = HAS_REMAP && wr_any && (paddr == `GPS_OFF_REMAP); // see R6

   // relocation controls stay zero on ports without the register
   assign cmp_moved = HAS_REMAP ? remap[3:0] : 4'h0;
   assign serial_high = HAS_REMAP && remap.serial0_relocate;
   assign sck_mosi_swap = HAS_REMAP && remap.spi_swap;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
         gps_pin_sense u_sense (
            .pclk(pclk),
            .presetn(presetn),
            .pclken(pclken),
            .pin_in(pin_in[gi]),
            .cfg(pin_config[gi]),
            .buffer_off_allowed(HAS_BUF_OFF), // see R18
            .pin_level(pin_level[gi]),
            .sense_hit(hit[gi])
         );
      end
   endgenerate

   // low level mode: flags while the pin is low, events while it is high
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         if (pin_config[i].sense_select == GPS_SENSE_LOW) begin
            pin_events[i] = ~hit[i]; // see R15, R17
         end else begin
            pin_events[i] = hit[i]; // see R15
         end
      end
   end

   // configuration registers, byte 0 of each word
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NUM_PINS; i++) begin
            pin_config[i] <= gps_pin_config_t'(`GPS_RST_BYTE);
         end
      end else if (wr_acc && pstrb[0] && is_pincfg(paddr)) begin
         pin_config[pincfg_idx(paddr)] <= gps_pin_config_t'(pwdata[7:0]); // see R11, R12, R13, R14
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq0_pin_select <= `GPS_RST_BYTE;
      end else if (wr_sel0) begin
         irq0_pin_select <= pwdata[7:0]; // see R1
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq1_pin_select <= `GPS_RST_BYTE;
      end else if (wr_sel1) begin
         irq1_pin_select <= pwdata[7:0]; // see R2
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_reg <= 4'h0;
      end else if (wr_level) begin
         level_reg <= pwdata[3:0]; // see R20
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin // see R6
      if (!presetn) begin
         remap <= gps_remap_t'(6'h00);
      end else if (wr_remap) begin
         remap <= gps_remap_t'(pwdata[5:0]);
      end
   end

   // source events from selected pins
   assign set_ev[0] = |(hit & irq0_pin_select[NUM_PINS-1:0]); // see R1, R3
   assign set_ev[1] = |(hit & irq1_pin_select[NUM_PINS-1:0]); // see R2, R3
   assign clr_ev = wr_flags ? pwdata[1:0] : 2'b00;

   // a set in the same cycle as a clear wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_irq_flag <= 2'b00;
      end else if (pclken) begin
         port_irq_flag <= (port_irq_flag & ~clr_ev) | set_ev; // see R3, R4
      end
   end

   assign irq_req[0] = port_irq_flag[0] && (level_reg[1:0] != 2'b00); // see R20
   assign irq_req[1] = port_irq_flag[1] && (level_reg[3:2] != 2'b00); // see R20
   assign irq_priority_level = level_reg;

   // read mux, registered in the setup phase
   always_comb begin
      next_prdata = 32'h0000_0000;
      if (paddr == `GPS_OFF_IRQ0_SEL) begin
         next_prdata[7:0] = irq0_pin_select;
      end else if (paddr == `GPS_OFF_IRQ1_SEL) begin
         next_prdata[7:0] = irq1_pin_select;
      end else if (paddr == `GPS_OFF_IRQ_LEVEL) begin
         next_prdata[3:0] = level_reg;
      end else if (paddr == `GPS_OFF_FLAGS) begin
         next_prdata[1:0] = port_irq_flag; // see R5
      end else if (paddr == `GPS_OFF_REMAP && HAS_REMAP) begin
         next_prdata[5:0] = remap;
      end else if (paddr == `GPS_OFF_INPUT) begin
         next_prdata[NUM_PINS-1:0] = pin_level; // see R21
      end else if (is_pincfg(paddr)) begin
         next_prdata[7:0] = pin_config[pincfg_idx(paddr)];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (pclken && rd_acc) begin
         prdata <= next_prdata;
      end
   end

   // peripheral routing onto pins
   always_comb begin
      drv_val = port_out;
      drv_en = port_dir;
      // timer compare outputs, low or high nibble
      for (int k = 0; k < 4; k++) begin
         logic rel;
         rel = 1'b0;
         rel = cmp_moved[k]; // see R9
         if (periph.cmp_oe[k]) begin
            drv_val[rel ? k + 4 : k] = periph.cmp_out[k];
            drv_en[rel ? k + 4 : k] = 1'b1;
         end
      end
      // shared pin carries OR of both timers
      for (int k = 0; k < 2; k++) begin
         if (cmp_moved[k] && periph.cmp_oe[k] && periph.t1_pwm_oe[k]) begin
            drv_val[k + 4] = periph.cmp_out[k] | periph.t1_pwm[k]; // see R10
         end else if (periph.t1_pwm_oe[k] && !(cmp_moved[k] && periph.cmp_oe[k])) begin
            drv_val[k + 4] = periph.t1_pwm[k];
            drv_en[k + 4] = 1'b1;
         end
      end
      for (int k = 0; k < 4; k++) begin
         int p;
         logic [1:0] lane;
         p = 0;
         lane = 2'(k);
         // lane 1 is MOSI and lane 3 is SCK of the serial unit
         if (sck_mosi_swap && (k == 1 || k == 3)) begin // see R7
            lane = (k == 1) ? 2'd3 : 2'd1;
         end
         p = serial_high ? int'(lane) + 4 : int'(lane); // see R8
         if (periph.serial_oe[k]) begin
            drv_val[p] = periph.serial_out[k];
            drv_en[p] = 1'b1;
         end
      end
   end

   // per-pin attributes that do not depend on the drive
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         pin_slew_limit[i] = pin_config[i].slew_limit_on; // see R11
         pin_buffer_off[i] = HAS_BUF_OFF && (pin_config[i].sense_select == GPS_INPUT_BUFFER_OFF); // see R16, R18
      end
   end

   // output stage per drive mode
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         logic v;
         v = 1'b0;
         v = drv_val[i] ^ pin_config[i].pin_invert; // see R12
         pin_out[i] = v;
         pin_oe[i] = drv_en[i];
         pin_pullup[i] = 1'b0;
         pin_pulldown[i] = 1'b0;
         pin_keeper[i] = 1'b0;
         unique case (pin_config[i].drive_pull_select) // see R13
            GPS_TOTEM: ;
            GPS_HOLD_LAST_LEVEL: pin_keeper[i] = 1'b1;
            GPS_PULL_DOWN: pin_pulldown[i] = !drv_en[i];
            GPS_PULL_UP: pin_pullup[i] = !drv_en[i];
            GPS_WIRED_OR: pin_oe[i] = drv_en[i] && v;
            GPS_WIRED_AND: pin_oe[i] = drv_en[i] && !v;
            GPS_OPEN_SOURCE_WITH_PULLDOWN: begin
               pin_oe[i] = drv_en[i] && v;
               pin_pulldown[i] = 1'b1;
            end
            GPS_OPEN_DRAIN_WITH_PULLUP: begin
               pin_oe[i] = drv_en[i] && !v;
               pin_pullup[i] = 1'b1;
            end
         endcase
      end
   end
endmodule // gps_port

// ### tb/gpio_pin_sense_remap_bench.sv
// self-checking bench of the pin sense and remap port
module gpio_pin_sense_remap_bench
   import gps_pkg::*;
   ();
   timeunit 1ns;
   timeprecision 1ns;
   `include "gps_map.svh"
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic pclken = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] r;
   logic [7:0] port_out = 8'h00;
   logic [7:0] port_dir = 8'h00;
   logic [7:0] ext_val = 8'h00;
   logic [7:0] pin_in, pin_out, pin_oe, pin_pullup, pin_pulldown, pin_keeper;
   logic [7:0] pin_slew_limit, pin_buffer_off, pin_events, pin_level;
   gps_periph_t periph = '0;
   logic pready;
   logic pslverr;
   logic [1:0] irq_req;
   logic [3:0] irq_priority_level;
   int mismatches = 0;
   int checks_done = 0;
   int cycles = 0;
   initial forever #50 pclk = ~pclk;
   gps_port gps_port_i (.pclk(pclk), .presetn(presetn), .pclken(pclken), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h1), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pin_in(pin_in), .port_out(port_out), .port_dir(port_dir), .periph(periph),
      .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .pin_pulldown(pin_pulldown),
      .pin_keeper(pin_keeper), .pin_slew_limit(pin_slew_limit), .pin_buffer_off(pin_buffer_off),
      .pin_events(pin_events), .pin_level(pin_level), .irq_req(irq_req),
      .irq_priority_level(irq_priority_level));
   gps_pad_model gps_pad_model_i (.ext_val(ext_val), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(r, e);
   endtask
   task automatic pins(input logic [7:0] v);
      ext_val <= v;
      repeat (5) @(posedge pclk);
   endtask
   task automatic rm(input logic [7:0] v, input logic [23:0] p, input logic [15:0] m, input logic [15:0] e);
      apb(1'b1, `GPS_OFF_REMAP, {24'h0, v});
      periph <= p;
      @(posedge pclk);
      #1;
      chk({pin_oe, pin_out} & m, e);
   endtask
   task automatic t_reset;
      rd_chk(`GPS_OFF_IRQ_LEVEL, 32'h0);
      rd_chk(`GPS_OFF_IRQ0_SEL, 32'h0);
      rd_chk(`GPS_OFF_IRQ1_SEL, 32'h0);
      rd_chk(`GPS_OFF_FLAGS, 32'h0);
      rd_chk(`GPS_OFF_REMAP, 32'h0);
      rd_chk(`GPS_OFF_PINCFG0, 32'h0);
      rd_chk(12'h0f0, 32'h0);
      $display("reset done");
   endtask
   task automatic t_masks;
      apb(1'b1, `GPS_OFF_IRQ0_SEL, 32'h01);
      apb(1'b1, `GPS_OFF_IRQ1_SEL, 32'h02);
      pins(8'h02);
      rd_chk(`GPS_OFF_FLAGS, 32'h2);
      chk(irq_req, 2'b00);
      apb(1'b1, `GPS_OFF_IRQ_LEVEL, 32'h04);
      #1;
      chk(irq_req, 2'b10);
      apb(1'b1, `GPS_OFF_FLAGS, 32'h01);
      rd_chk(`GPS_OFF_FLAGS, 32'h2);
      apb(1'b1, `GPS_OFF_FLAGS, 32'h02);
      rd_chk(`GPS_OFF_FLAGS, 32'h0);
      pins(8'h00);
      $display("masks done");
   endtask
   task automatic t_sense;
      for (int m = 0; m < 3; m++) begin
         apb(1'b1, `GPS_OFF_PINCFG0, 32'(m));
         apb(1'b1, `GPS_OFF_FLAGS, 32'h3);
         pins(8'h01);
         rd_chk(`GPS_OFF_FLAGS, {31'h0, m != 2});
         apb(1'b1, `GPS_OFF_FLAGS, 32'h3);
         pins(8'h00);
         rd_chk(`GPS_OFF_FLAGS, {31'h0, m != 1});
      end
      $display("sense done");
   endtask
   task automatic t_low;
      apb(1'b1, `GPS_OFF_PINCFG0, 32'h3);
      pins(8'h01);
      chk(pin_events[0], 1'b1);
      apb(1'b1, `GPS_OFF_FLAGS, 32'h3);
      chk(pin_events[0], 1'b1);
      rd_chk(`GPS_OFF_FLAGS, 32'h0);
      pins(8'h00);
      chk(pin_events[0], 1'b0);
      rd_chk(`GPS_OFF_FLAGS, 32'h1);
      apb(1'b1, `GPS_OFF_PINCFG0, 32'h0);
      apb(1'b1, `GPS_OFF_FLAGS, 32'h3);
      $display("low level done");
   endtask
   task automatic t_invert;
      apb(1'b1, 12'h044, 32'h40);
      pins(8'h02);
      rd_chk(`GPS_OFF_INPUT, 32'h0);
      port_dir <= 8'h02;
      port_out <= 8'h02;
      @(posedge pclk);
      #1;
      chk(pin_out[1], 1'b0);
      port_dir <= 8'h00;
      pins(8'h00);
      rd_chk(`GPS_OFF_INPUT, 32'h2);
      apb(1'b1, 12'h044, 32'h0);
      $display("invert done");
   endtask
   task automatic t_bufoff;
      apb(1'b1, 12'h048, 32'h7);
      apb(1'b1, `GPS_OFF_IRQ0_SEL, 32'h04);
      apb(1'b1, `GPS_OFF_FLAGS, 32'h3);
      pins(8'h0c);
      chk(pin_buffer_off[2], 1'b1);
      apb(1'b0, `GPS_OFF_INPUT, 32'h0);
      chk(r & 32'h0c, 32'h08);
      rd_chk(`GPS_OFF_FLAGS, 32'h0);
      pins(8'h00);
      apb(1'b1, 12'h048, 32'h0);
      $display("buffer off done");
   endtask
   task automatic t_drive;
      for (int m = 0; m < 8; m++) begin
         apb(1'b1, 12'h04c, {24'h0, m[0], 1'b0, m[2:0], 3'b000});
         #1;
         chk({pin_slew_limit[3], pin_keeper[3], pin_pulldown[3], pin_pullup[3]},
            {m[0], m == 1, m == 2 || m == 6, m == 3 || m == 7});
      end
      $display("drive done");
   endtask
   task automatic t_remap;
      apb(1'b1, `GPS_OFF_REMAP, 32'hff);
      rd_chk(`GPS_OFF_REMAP, 32'h3f);
      rm(8'h08, 24'h880000, 16'h8880, 16'h8080);
      rm(8'h01, 24'h011100, 16'h1010, 16'h1010);
      rm(8'h10, 24'h000011, 16'h1110, 16'h1010);
      rm(8'h20, 24'h00002a, 16'h000a, 16'h0008);
      rm(8'h00, 24'h000000, 16'hff00, 16'h0000);
      $display("remap done");
   endtask
   task automatic t_freeze;
      pclken <= 1'b0;
      apb(1'b1, `GPS_OFF_IRQ0_SEL, 32'h55);
      pclken <= 1'b1;
      rd_chk(`GPS_OFF_IRQ0_SEL, 32'h04);
      $display("freeze done");
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         conclude;
      end
   end
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_masks;
      t_sense;
      t_low;
      t_invert;
      t_bufoff;
      t_drive;
      t_remap;
      t_freeze;
      conclude;
   end
endmodule // gpio_pin_sense_remap_bench

// ### tb/gps_monitor.sv
// checker bound to the port's bus and pin outputs
module gps_monitor
   import gps_pkg::*;
#(
   parameter int PORT_INDEX = 2,
   parameter int NUM_PINS = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pclken,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [NUM_PINS-1:0] pin_keeper,
   input wire logic [NUM_PINS-1:0] pin_slew_limit,
   input wire logic [NUM_PINS-1:0] pin_buffer_off,
   input wire logic [NUM_PINS-1:0] pin_level,
   input wire logic [1:0] irq_req,
   input wire logic [3:0] irq_priority_level
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic wr;
   logic w2;
   logic w3;
   assign wr = psel && penable && pwrite && pclken && pstrb[0];
   assign w2 = wr && paddr == 12'h048;
   assign w3 = wr && paddr == 12'h04c;
   AST_READY: assert property (psel && penable |-> pready) else $error("access without ready");
   AST_NO_ERR: assert property (!pslverr) else $error("error response");
   AST_LVL0: assert property (irq_priority_level[1:0] == 2'b00 |-> !irq_req[0]) else $error("req0 at level 0");
   AST_LVL1: assert property (irq_priority_level[3:2] == 2'b00 |-> !irq_req[1]) else $error("req1 at level 0");
   AST_SLEW: assert property (w3 |=> pin_slew_limit[3] == $past(pwdata[7])) else $error("slew bit");
   AST_KEEP: assert property (w3 |=> pin_keeper[3] == ($past(pwdata[5:3]) == 3'b001)) else $error("keeper");
   AST_BUF_OFF: assert property (w2 |=> pin_buffer_off[2] == (PORT_INDEX < 6 && $past(pwdata[2:0]) == 3'b111))
      else $error("buffer off");
   AST_HOLD: assert property (irq_req[1] && !(psel && pwrite) |=> irq_req[1]) else $error("flag lost");
   AST_FROZEN: assert property (pin_buffer_off[2] && $past(pin_buffer_off[2], 4) |-> $stable(pin_level[2]))
      else $error("sampled while off");
   COV_REQ1: cover property (irq_req[1]);
   COV_SLEW: cover property (pin_slew_limit[3]);
   COV_OFF: cover property (pin_buffer_off[2]);
endmodule // gps_monitor

bind gps_port gps_monitor #(.PORT_INDEX(PORT_INDEX), .NUM_PINS(NUM_PINS)) gps_monitor_i (
   .pclk(pclk), .presetn(presetn), .pclken(pclken), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
   .pslverr(pslverr), .pin_keeper(pin_keeper), .pin_slew_limit(pin_slew_limit),
   .pin_buffer_off(pin_buffer_off), .pin_level(pin_level), .irq_req(irq_req),
   .irq_priority_level(irq_priority_level));

// ### tb/gps_pad_model.sv
// pad model: a driven pin shows the port's drive, else the outside level
module gps_pad_model (
   input wire logic [7:0] ext_val,
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   output logic [7:0] pin_in
);
   timeunit 1ns;
   timeprecision 1ns;
   always_comb begin
      for (int k = 0; k < 8; k++) begin
         pin_in[k] = pin_oe[k] ? pin_out[k] : ext_val[k];
      end
   end
endmodule // gps_pad_model
